/* jbvm_master.sv */
// JTAG bit/vector master: register port, TCK sequencer and TDO capture
//
// Overview of operation
// RQ1: Two ways to drive the JTAG lines: per-line bit mode and vector mode.
// RQ2: Bit mode: software sets TCK, TMS, TDI and reads TDO independently.
// RQ3: With bit-mode enable at 1, line outputs follow the written line bits.
// RQ4: Software makes each TCK high and low phase by separate writes.
// RQ5: Vector mode puts bit n of TMS and TDI words out in one TCK cycle.
// RQ6: Bit 0 of both vectors appears first, higher bits in later cycles.
// RQ7: A request yields exactly the programmed count of 50% duty TCK cycles.
// RQ8: Vector TCK rate comes from the clock via a programmable divider.
// RQ9: Requests accepted only with vector enable 1 and status idle (01).
// RQ10: Requests arriving while busy are dropped, never queued.
// RQ11: Transfer length is not checked against vector width.
// RQ12: Software programs length to match vectors or TDO bits wanted.
// RQ13: TMS and TDI change right after each TCK falling edge.
// RQ14: Cycles beyond the defined vector data shift out zero bits.
// RQ15: TDO is sampled at every TCK rising edge for shift and get.
// RQ16: Each captured TDO bit shows in the TDO word at once.
// RQ17: TDO word bit 0 holds the newest capture, older bits higher up.
// RQ18: When done, TCK parks low and status returns to idle.
`timescale 1ns/10ps
module jbvm_master
  import jbvm_pkg::*;
#(
  parameter int FIFO_DEPTH = jbvm_pkg::JBVM_FIFO_DEPTH
) (
  input  wire logic                             ref_clk, // 200 MHz clock
  input  wire logic                             rst_n,   // Async reset
  input  wire logic [jbvm_pkg::JBVM_ADDR_W-1:0] addr,    // Byte address
  input  wire logic [jbvm_pkg::JBVM_DATA_W-1:0] wdata,   // Write data
  input  wire logic                             wr,      // Write strobe
  input  wire logic                             rd,      // Read strobe
  output logic      [jbvm_pkg::JBVM_DATA_W-1:0] rdata,   // Read data, +1 cyc
  output logic                                  tck,     // JTAG clock out
  output logic                                  tms,     // JTAG mode out
  output logic                                  tdi,     // JTAG data out
  input  wire logic                             tdo      // JTAG data in
);

  import jbvm_pkg::*;

  jbvm_regs_t                  cur;
  jbvm_regs_t                  next_cur;

  logic                        fifo_in_valid;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_out_ready;
  logic [JBVM_VEC_W-1:0]       fifo_out_data;
  logic [JBVM_CNT_W-1:0]       fifo_level;

  logic                        wr_ctrl;
  logic                        wr_bits;
  logic                        wr_cmd;
  logic                        shift_req;
  logic                        get_req;
  logic                        accept;
  logic                        half_done;
  logic [1:0]                  status;
  jbvm_jtag_t                  vec_lines;

  // Finished TDO words queue here; a full queue holds the sequencer back
  jbvm_fifo #(
    .WIDTH (JBVM_VEC_W),
    .DEPTH (FIFO_DEPTH),
    .CNT_W (JBVM_CNT_W)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (cur.vector_tdo_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Queue is fed from the push state; a read of its port pops the head
  assign fifo_in_valid  = (cur.state == JBVM_PUSH);
  assign fifo_out_ready = rd && (addr == JBVM_OFF_FIFO);

  assign wr_ctrl   = wr && (addr == JBVM_OFF_CTRL);
  assign wr_bits   = wr && (addr == JBVM_OFF_BITS);
  assign wr_cmd    = wr && (addr == JBVM_OFF_CMD);
  assign shift_req = wr_cmd && wdata[JBVM_CMD_SHIFT];
  assign get_req   = wr_cmd && wdata[JBVM_CMD_GET];

  // Shift wins when software sets both request bits in one write
  assign accept = (shift_req || get_req)
                  && cur.vector_mode_enable
                  && (cur.state == JBVM_IDLE); // see RQ9, see RQ10

  // Both TCK halves last divider+1 clocks, giving an even duty cycle
  // Divider is read live: a rewrite mid-run bends the tck period
  assign half_done = (cur.half_cnt == cur.vector_tck_divider); // see RQ8

  // Waiting to queue counts as not idle, so requests are refused then
  always_comb
  begin
    status = JBVM_STAT_IDLE;
    case (cur.state)
      JBVM_IDLE: status = JBVM_STAT_IDLE;
      JBVM_LOW:  status = JBVM_STAT_BUSY;
      JBVM_HIGH: status = JBVM_STAT_BUSY;
      JBVM_PUSH: status = JBVM_STAT_WAIT;
      default:   status = JBVM_STAT_BUSY;
    endcase
  end

  always_comb
  begin
    next_cur = cur;

    // Register writes
    // Vectors and length are copied at accept, so rewrites are safe mid-run
    if (wr_ctrl)
    begin
      next_cur.bit_mode_enable    = wdata[JBVM_CTRL_BIT_EN];
      next_cur.vector_mode_enable = wdata[JBVM_CTRL_VEC_EN];
    end
    if (wr_bits)
    begin
      // Each line stored on its own; software toggles tck itself
      next_cur.bit_mode_line_bits.tck = wdata[JBVM_BITS_TCK]; // see RQ2
      next_cur.bit_mode_line_bits.tms = wdata[JBVM_BITS_TMS]; // see RQ2
      next_cur.bit_mode_line_bits.tdi = wdata[JBVM_BITS_TDI]; // see RQ2
    end
    if (wr && (addr == JBVM_OFF_TMS))
    begin
      next_cur.vector_tms_word = wdata[JBVM_VEC_W-1:0];
    end
    if (wr && (addr == JBVM_OFF_TDI))
    begin
      next_cur.vector_tdi_word = wdata[JBVM_VEC_W-1:0];
    end
    if (wr && (addr == JBVM_OFF_LEN))
    begin
      next_cur.vector_transfer_length = wdata[JBVM_LEN_W-1:0];
    end
    if (wr && (addr == JBVM_OFF_DIV))
    begin
      next_cur.vector_tck_divider = wdata[JBVM_DIV_W-1:0];
    end

    // Vector sequencer
    case (cur.state)
      JBVM_IDLE:
      begin
        if (accept)
        begin
          // Get requests hold tms and tdi low for the whole transfer
          next_cur.tms_shift = shift_req ? cur.vector_tms_word : '0;
          next_cur.tdi_shift = shift_req ? cur.vector_tdi_word : '0;
          // Length taken as is, even beyond the vector width
          next_cur.remain   = cur.vector_transfer_length; // see RQ11
          next_cur.half_cnt = '0;
          if (cur.vector_transfer_length == '0)
          begin
            next_cur.state = JBVM_PUSH; // see RQ7
          end
          else
          begin
            next_cur.state = JBVM_LOW;
          end
        end
      end
      JBVM_LOW:
      begin
        if (half_done)
        begin
          next_cur.half_cnt = '0;
          next_cur.state    = JBVM_HIGH;
          // Newest bit enters at bit 0, visible straight away
          next_cur.vector_tdo_word =
            {cur.vector_tdo_word[JBVM_VEC_W-2:0], tdo}; // see RQ15, see RQ17
        end
        else
        begin
          next_cur.half_cnt = cur.half_cnt + 1'b1;
        end
      end
      JBVM_HIGH:
      begin
        if (half_done)
        begin
          next_cur.half_cnt = '0;
          next_cur.remain   = cur.remain - 1'b1;
          // Next bit moves down on the falling edge; zeros fill from the top
          next_cur.tms_shift = {1'b0, cur.tms_shift[JBVM_VEC_W-1:1]};
          next_cur.tdi_shift = {1'b0, cur.tdi_shift[JBVM_VEC_W-1:1]};
          if (cur.remain == JBVM_LEN_W'(1))
          begin
            next_cur.state = JBVM_PUSH; // see RQ7, see RQ18
          end
          else
          begin
            next_cur.state = JBVM_LOW; // see RQ13, see RQ14
          end
        end
        else
        begin
          next_cur.half_cnt = cur.half_cnt + 1'b1;
        end
      end
      JBVM_PUSH:
      begin
        // Waits here while the TDO queue is full, tck parked low
        if (fifo_in_ready)
        begin
          next_cur.state = JBVM_IDLE; // see RQ18
        end
      end
      default:
      begin
        next_cur.state = JBVM_IDLE;
      end
    endcase

    // Dropping vector enable aborts a running transfer
    if (!cur.vector_mode_enable && (cur.state != JBVM_IDLE))
    begin
      next_cur.state    = JBVM_IDLE;
      next_cur.half_cnt = '0;
    end

    // Line drive: bit mode first, then vector mode, otherwise all low
    vec_lines = '0;
    if ((next_cur.state == JBVM_LOW) || (next_cur.state == JBVM_HIGH))
    begin
      vec_lines.tck = (next_cur.state == JBVM_HIGH); // see RQ7
      vec_lines.tms = next_cur.tms_shift[0]; // see RQ5, see RQ6
      vec_lines.tdi = next_cur.tdi_shift[0]; // see RQ5, see RQ6
    end
    if (next_cur.bit_mode_enable)
    begin
      next_cur.jtag_out = next_cur.bit_mode_line_bits; // see RQ1, see RQ3
    end
    else if (next_cur.vector_mode_enable)
    begin
      next_cur.jtag_out = vec_lines; // see RQ1
    end
    else
    begin
      next_cur.jtag_out = '0;
    end

    // Read answer, registered for the next cycle; unmapped reads give zero
    next_cur.rdata = '0;
    if (rd)
    begin
      case (addr)
        JBVM_OFF_CTRL:
        begin
          next_cur.rdata[JBVM_CTRL_BIT_EN] = cur.bit_mode_enable;
          next_cur.rdata[JBVM_CTRL_VEC_EN] = cur.vector_mode_enable;
        end
        JBVM_OFF_BITS:
        begin
          next_cur.rdata[JBVM_BITS_TCK] = cur.bit_mode_line_bits.tck;
          next_cur.rdata[JBVM_BITS_TMS] = cur.bit_mode_line_bits.tms;
          next_cur.rdata[JBVM_BITS_TDI] = cur.bit_mode_line_bits.tdi;
          next_cur.rdata[JBVM_BITS_TDO] = tdo; // see RQ2
        end
        JBVM_OFF_TMS:
        begin
          next_cur.rdata[JBVM_VEC_W-1:0] = cur.vector_tms_word;
        end
        JBVM_OFF_TDI:
        begin
          next_cur.rdata[JBVM_VEC_W-1:0] = cur.vector_tdi_word;
        end
        JBVM_OFF_LEN:
        begin
          next_cur.rdata[JBVM_LEN_W-1:0] = cur.vector_transfer_length;
        end
        JBVM_OFF_DIV:
        begin
          next_cur.rdata[JBVM_DIV_W-1:0] = cur.vector_tck_divider;
        end
        JBVM_OFF_CMD:
        begin
          next_cur.rdata[JBVM_STAT_LSB +: 2] = status; // see RQ9
          next_cur.rdata[JBVM_STAT_VALID]    = fifo_out_valid;
          next_cur.rdata[JBVM_STAT_CNT +: JBVM_CNT_W] = fifo_level;
        end
        JBVM_OFF_TDO:
        begin
          next_cur.rdata[JBVM_VEC_W-1:0] = cur.vector_tdo_word; // see RQ16
        end
        JBVM_OFF_FIFO:
        begin
          // Reading pops the head word; an empty queue reads zero
          if (fifo_out_valid)
          begin
            next_cur.rdata[JBVM_VEC_W-1:0] = fifo_out_data;
          end
        end
        default:
        begin
          next_cur.rdata = '0;
        end
      endcase
    end
  end

  // Reset parks all lines low so the target sees no stray tck edge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur.bit_mode_enable        <= 1'b0;
      cur.vector_mode_enable     <= 1'b0;
      cur.bit_mode_line_bits     <= '0;
      cur.vector_tms_word        <= '0;
      cur.vector_tdi_word        <= '0;
      cur.vector_transfer_length <= JBVM_LEN_RST;
      cur.vector_tck_divider     <= JBVM_DIV_RST;
      cur.state                  <= JBVM_IDLE;
      cur.tms_shift              <= '0;
      cur.tdi_shift              <= '0;
      cur.remain                 <= '0;
      cur.half_cnt               <= '0;
      cur.vector_tdo_word        <= '0;
      cur.jtag_out               <= '0;
      cur.rdata                  <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Pins come straight from the state flops, no logic after them
  assign rdata = cur.rdata;
  assign tck   = cur.jtag_out.tck;
  assign tms   = cur.jtag_out.tms;
  assign tdi   = cur.jtag_out.tdi;

endmodule

/* jbvm_pkg.sv */
// Shared constants, register map and types of the JTAG bit/vector master
package jbvm_pkg;

  localparam int          JBVM_DATA_W     = 32;
  localparam int          JBVM_ADDR_W     = 8;
  localparam int          JBVM_VEC_W      = 32;
  localparam int          JBVM_LEN_W      = 16;
  localparam int          JBVM_DIV_W      = 16;
  localparam int          JBVM_FIFO_DEPTH = 16;
  localparam int          JBVM_CNT_W      = 5;

  localparam logic [7:0]  JBVM_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  JBVM_OFF_BITS   = 8'h04;
  localparam logic [7:0]  JBVM_OFF_TMS    = 8'h08;
  localparam logic [7:0]  JBVM_OFF_TDI    = 8'h0C;
  localparam logic [7:0]  JBVM_OFF_LEN    = 8'h10;
  localparam logic [7:0]  JBVM_OFF_DIV    = 8'h14;
  localparam logic [7:0]  JBVM_OFF_CMD    = 8'h18;
  localparam logic [7:0]  JBVM_OFF_TDO    = 8'h1C;
  localparam logic [7:0]  JBVM_OFF_FIFO   = 8'h20;

  // Control register fields
  localparam int          JBVM_CTRL_BIT_EN = 0;
  localparam int          JBVM_CTRL_VEC_EN = 1;
  // Bit-mode line fields; tdo is read only
  localparam int          JBVM_BITS_TCK   = 0;
  localparam int          JBVM_BITS_TMS   = 1;
  localparam int          JBVM_BITS_TDI   = 2;
  localparam int          JBVM_BITS_TDO   = 3;
  // Command / status fields
  localparam int          JBVM_CMD_SHIFT  = 0;
  localparam int          JBVM_CMD_GET    = 1;
  localparam int          JBVM_STAT_LSB   = 0;
  localparam int          JBVM_STAT_VALID = 2;
  localparam int          JBVM_STAT_CNT   = 8;

  localparam logic [1:0]  JBVM_STAT_IDLE  = 2'h1;
  localparam logic [1:0]  JBVM_STAT_BUSY  = 2'h2;
  localparam logic [1:0]  JBVM_STAT_WAIT  = 2'h3;

  localparam logic [JBVM_LEN_W-1:0] JBVM_LEN_RST = 16'h0000;
  localparam logic [JBVM_DIV_W-1:0] JBVM_DIV_RST = 16'h0000;

  typedef enum logic [3:0] {
    JBVM_IDLE = 4'b0001,
    JBVM_LOW  = 4'b0010,
    JBVM_HIGH = 4'b0100,
    JBVM_PUSH = 4'b1000
  } jbvm_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jbvm_jtag_t;

  typedef struct packed {
    logic                   bit_mode_enable;
    logic                   vector_mode_enable;
    jbvm_jtag_t             bit_mode_line_bits;
    logic [JBVM_VEC_W-1:0]  vector_tms_word;
    logic [JBVM_VEC_W-1:0]  vector_tdi_word;
    logic [JBVM_LEN_W-1:0]  vector_transfer_length;
    logic [JBVM_DIV_W-1:0]  vector_tck_divider;
    jbvm_state_t            state;
    logic [JBVM_VEC_W-1:0]  tms_shift;
    logic [JBVM_VEC_W-1:0]  tdi_shift;
    logic [JBVM_LEN_W-1:0]  remain;
    logic [JBVM_DIV_W-1:0]  half_cnt;
    logic [JBVM_VEC_W-1:0]  vector_tdo_word;
    jbvm_jtag_t             jtag_out;
    logic [JBVM_DATA_W-1:0] rdata;
  } jbvm_regs_t;

endpackage

/* jbvm_fifo.sv */
// Small synchronous FIFO holding finished TDO words
`timescale 1ns/10ps
module jbvm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  input  wire logic             ref_clk,   // System clock
  input  wire logic             rst_n,     // Asynchronous reset, active low
  input  wire logic             in_valid,  // Word offered
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Word to store
  output logic                  out_valid, // Head word present
  input  wire logic             out_ready, // Head word taken
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic      [CNT_W-1:0] level      // Words stored
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != CNT_W'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap explicitly so any depth works, not only powers of two
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        level <= level + 1'b1;
      end
      else if (pop && !push)
      begin
        level <= level - 1'b1;
      end
    end
  end

endmodule

/* jbvm_master_sva.sv */
// Port-level assertions for the JTAG bit/vector master
`timescale 1ns/10ps
module jbvm_master_sva
  import jbvm_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic        ref_clk, // Clock
  input wire logic        rst_n,   // Reset, active low
  input wire logic [7:0]  addr,    // Byte address
  input wire logic [31:0] wdata,   // Write data
  input wire logic        wr,      // Write strobe
  input wire logic        rd,      // Read strobe
  input wire logic [31:0] rdata,   // Read data
  input wire logic        tck,     // JTAG clock
  input wire logic        tms,     // JTAG mode
  input wire logic        tdi,     // JTAG data out
  input wire logic        tdo      // JTAG data in
);
  logic        bit_en;
  logic        vec_en;
  logic        tck_d;
  logic        vec;
  logic [15:0] div_q;
  logic [15:0] run;
  assign vec = vec_en && !bit_en;
  // Run length of the current tck level; zeroed outside vector mode
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      bit_en <= 1'b0;
      vec_en <= 1'b0;
      div_q  <= 16'h0000;
      tck_d  <= 1'b0;
      run    <= 16'h0000;
    end
    else
    begin
      if (wr && addr == JBVM_OFF_CTRL)
      begin
        bit_en <= wdata[0];
        vec_en <= wdata[1];
      end
      if (wr && addr == JBVM_OFF_DIV)
        div_q <= wdata[15:0];
      tck_d <= tck;
      run   <= !vec ? 16'h0000 : (tck != tck_d) ? 16'h0001 : run + 16'h0001;
    end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_bit_lines;
    wr && addr == JBVM_OFF_BITS && bit_en |=> tck == $past(wdata[0])
      && tms == $past(wdata[1]) && tdi == $past(wdata[2]);
  endproperty
  a_bit_lines: assert property (p_bit_lines)
    else $error("bit mode lines differ from written bits");
  property p_bit_hold;
    bit_en && $past(bit_en) && !$past(wr) |-> $stable({tck, tms, tdi});
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("bit mode lines moved without a write");
  property p_tdo_live;
    rd && addr == JBVM_OFF_BITS |=> rdata[3] == $past(tdo);
  endproperty
  a_tdo_live: assert property (p_tdo_live)
    else $error("tdo readback not the live level");
  property p_drop_off;
    wr && addr == JBVM_OFF_CMD && !vec_en && !bit_en |=> (!tck) [*4];
  endproperty
  a_drop_off: assert property (p_drop_off)
    else $error("request ran with vector mode off");
  property p_high_len;
    vec && !tck && tck_d && run != 16'h0000 |-> run == div_q + 16'h0001;
  endproperty
  a_high_len: assert property (p_high_len)
    else $error("tck high phase length wrong");
  property p_data_at_low;
    vec && ($changed(tms) || $changed(tdi)) |-> !tck;
  endproperty
  a_data_at_low: assert property (p_data_at_low)
    else $error("tms or tdi changed while tck high");
  property p_ctrl_read;
    rd && addr == JBVM_OFF_CTRL |=>
      rdata == {30'h0, $past(vec_en), $past(bit_en)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control readback wrong");
  property p_unmapped;
    rd && addr > JBVM_OFF_FIFO |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_gap;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_gap: assert property (p_rdata_gap)
    else $error("read data outside its cycle");
  c_vec_rise: cover property (vec && $rose(tck));
  c_bit_write: cover property (wr && addr == JBVM_OFF_BITS && bit_en);
  c_drop: cover property (wr && addr == JBVM_OFF_CMD && !vec_en);
endmodule

bind jbvm_master jbvm_master_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_jbvm_master_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

/* jbvm_tap_model.sv */
// Behavioural JTAG test access port at the far side of the master
`timescale 1ns/10ps
module jbvm_tap_model (
  input  wire logic tck, // JTAG clock
  input  wire logic tms, // Mode select
  input  wire logic tdi, // Data in
  output logic      tdo  // Data out
);
  logic [63:0] pat = 64'h0;
  logic [63:0] tms_got = 64'h0;
  logic [63:0] tdi_got = 64'h0;
  logic [7:0]  cnt = 8'h00;
  initial
    tdo = 1'b0;
  task automatic start(input logic [63:0] p);
    pat = p;
    tms_got = 64'h0;
    tdi_got = 64'h0;
    cnt = 8'h00;
    tdo = p[0];
  endtask
  // Inputs taken on the rising edge, as a real port does
  always @(posedge tck)
  begin
    tms_got[cnt[5:0]] <= tms;
    tdi_got[cnt[5:0]] <= tdi;
    cnt <= cnt + 8'h01;
  end
  // Output moves on the falling edge so it is settled by the next rise
  always @(negedge tck)
    tdo <= pat[cnt[5:0]];
endmodule

/* tb_jtag_bit_vector_master.sv */
// Self-checking bench for the JTAG bit/vector master
`timescale 1ns/10ps
module tb_jtag_bit_vector_master;
  import jbvm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic [31:0] seed = 32'h881E4CA9;
  logic [31:0] d;
  logic [31:0] tmsv;
  logic [31:0] tdiv;
  logic [31:0] expw;
  logic [63:0] pat;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          len;
  int          div;
  int          k;
  int          lens[5] = '{2, 0, 32, 40, 1};
  int          divs[5] = '{0, 0, 1, 2, 3};
  always #2.5 ref_clk = ~ref_clk;
  jbvm_master #(.FIFO_DEPTH(JBVM_FIFO_DEPTH)) u_jbvm_master (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jbvm_tap_model u_jbvm_tap_model (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Bits a shift puts on the wire; zeros once the word runs out
  function automatic logic [63:0] vec_exp(input logic [31:0] w, input int n);
    vec_exp = 64'h0;
    for (int j = 0; j < n && j < 32; j++)
      vec_exp[j] = w[j];
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Runs far past the longest transfer set, so only a hang reaches it
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      n_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(JBVM_OFF_CTRL, d);
    chk(d, 0);
    rd_reg(JBVM_OFF_CMD, d);
    chk(d, 32'h1);
    rd_reg(8'h24, d);
    chk(d, 0);
    u_jbvm_tap_model.start({seed, ~seed});
    wr_reg(JBVM_OFF_CTRL, 32'h1);
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      wr_reg(JBVM_OFF_BITS, {29'h0, seed[2:0]});
      #1;
      chk({tck, tms, tdi}, {seed[0], seed[1], seed[2]});
      rd_reg(JBVM_OFF_BITS, d);
      chk(d, {28'h0, tdo, seed[2:0]});
    end
    wr_reg(JBVM_OFF_CTRL, 32'h2);
    expw = 32'h0;
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      tmsv = seed;
      seed = xs(seed);
      tdiv = seed;
      seed = xs(seed);
      pat = {seed, tmsv ^ tdiv};
      len = (i < 5) ? lens[i] : int'(seed[31:26]) % 41;
      div = (i < 5) ? divs[i] : int'(seed[1:0]);
      wr_reg(JBVM_OFF_TMS, tmsv);
      wr_reg(JBVM_OFF_TDI, tdiv);
      wr_reg(JBVM_OFF_LEN, 32'(len));
      wr_reg(JBVM_OFF_DIV, 32'(div));
      u_jbvm_tap_model.start(pat);
      wr_reg(JBVM_OFF_CMD, (i % 2 == 1) ? 32'h2 : 32'h1);
      if (len > 0)
        wr_reg(JBVM_OFF_CMD, 32'h1);
      // Mid-transfer read: exactly one bit captured so far at this divider
      if (i == 3)
      begin
        rd_reg(JBVM_OFF_TDO, d);
        chk(d, {expw[30:0], pat[0]});
      end
      d = 32'h0;
      for (k = 0; k < 500 && d[1:0] !== JBVM_STAT_IDLE; k++)
        rd_reg(JBVM_OFF_CMD, d);
      chk(d[1:0], JBVM_STAT_IDLE);
      chk(tck, 0);
      chk(u_jbvm_tap_model.cnt, len);
      chk(u_jbvm_tap_model.tms_got, i[0] ? 0 : vec_exp(tmsv, len));
      chk(u_jbvm_tap_model.tdi_got, i[0] ? 0 : vec_exp(tdiv, len));
      for (k = 0; k < len; k++)
        expw = {expw[30:0], pat[k]};
      rd_reg(JBVM_OFF_TDO, d);
      chk(d, expw);
      rd_reg(JBVM_OFF_FIFO, d);
      chk(d, expw);
      rd_reg(JBVM_OFF_TMS, d);
      chk(d, tmsv);
    end
    // Sixteen empty transfers fill the TDO queue; one more must wait in 11
    wr_reg(JBVM_OFF_LEN, 32'h0);
    for (int i = 0; i < 17; i++)
      wr_reg(JBVM_OFF_CMD, 32'h1);
    rd_reg(JBVM_OFF_CMD, d);
    chk(d, 32'h0000_1007);
    for (int i = 0; i < 17; i++)
    begin
      rd_reg(JBVM_OFF_FIFO, d);
      chk(d, expw);
    end
    rd_reg(JBVM_OFF_CMD, d);
    chk(d, 32'h1);
    rd_reg(JBVM_OFF_FIFO, d);
    chk(d, 0);
    wr_reg(JBVM_OFF_CTRL, 32'h0);
    u_jbvm_tap_model.start(64'h0);
    wr_reg(JBVM_OFF_CMD, 32'h1);
    repeat (10) @(posedge ref_clk);
    chk(u_jbvm_tap_model.cnt, 0);
    tally_and_finish();
  end
endmodule
